//--- core/cid_pkg.sv
// Constants and carriers for the identification register bank.
// Assumes a coprocessor access port driven on core_clk by the pipeline.
package cid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Coprocessor encodings
  localparam logic [2:0] CID_OPC1_ISA = 3'h0;
  localparam logic [3:0] CID_CRN_ISA = 4'h0;
  localparam logic [3:0] CID_CRM_ISA = 4'h2;
  localparam logic [2:0] CID_OPC2_ISA4 = 3'h4;
  localparam logic [2:0] CID_OPC2_ISA5 = 3'h5;
  localparam logic [2:0] CID_OPC1_CCS = 3'h1;
  localparam logic [3:0] CID_CRN_CCS = 4'h0;
  localparam logic [3:0] CID_CRM_CCS = 4'h0;
  localparam logic [2:0] CID_OPC2_CCS = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Fourth attribute register fields, high nibble first
  localparam logic [3:0] CID_ISA4_SWAP = 4'h1;
  localparam logic [3:0] CID_ISA4_PSRM = 4'h0;
  localparam logic [3:0] CID_ISA4_SYNCF = 4'h0;
  localparam logic [3:0] CID_ISA4_BARRIER = 4'h1;
  localparam logic [3:0] CID_ISA4_SECURE_CALL = 4'h1;
  localparam logic [3:0] CID_ISA4_WRITEBACK = 4'h1;
  localparam logic [3:0] CID_ISA4_SHIFT = 4'h4;
  localparam logic [3:0] CID_ISA4_UNPRIV = 4'h2;
  localparam logic [31:0] CID_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Selection values
  localparam logic [3:0] CID_SEL_L1D = 4'h0;
  localparam logic [3:0] CID_SEL_L1I = 4'h1;
  localparam logic [3:0] CID_SEL_L2 = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Cache geometry defaults
  localparam logic [14:0] CID_L1D_SETS = 15'h007F;
  localparam logic [14:0] CID_L1I_SETS = 15'h01FF;
  localparam logic [14:0] CID_L2_SETS = 15'h03FF;
  localparam logic [9:0] CID_L1D_WAYS = 10'h003;
  localparam logic [9:0] CID_L1I_WAYS = 10'h001;
  localparam logic [9:0] CID_L2_WAYS = 10'h007;
  localparam logic [2:0] CID_LINE_8W = 3'h1;
  localparam logic [2:0] CID_LINE_16W = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic pl1;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } cid_req_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [31:0] rdata;
  } cid_rsp_t;

  typedef struct packed {
    logic write_through_flag;
    logic write_back_flag;
    logic read_allocate_flag;
    logic write_allocate_flag;
    logic [14:0] set_count_minus_one;
    logic [9:0] ways_minus_one;
    logic [2:0] line_length_code;
  } cid_ccs_t;

  typedef enum logic [1:0] {
    CID_REG_NONE = 2'b00,
    CID_REG_ISA4 = 2'b01,
    CID_REG_ISA5 = 2'b10,
    CID_REG_CCS = 2'b11
  } cid_reg_t;

  typedef enum logic [0:0] {
    CID_IDLE = 1'b0,
    CID_ANSWER = 1'b1
  } cid_state_t;

  typedef struct packed {
    cid_state_t state;
    cid_rsp_t rsp;
  } cid_regs_t;

endpackage

//--- core/cid_bank.sv
// Identification register bank of the system control coprocessor.
// Assumes requests arrive on core_clk from the pipeline, with the
// privilege and selection value from same-clock logic.
//
// Operation
// R1 - Barrier field, bits 19:16 of attribute register four, reads 0x1.
// R2 - Secure call field, bits 15:12, reads 0x1.
// R3 - Write-back addressing field, bits 11:8, reads 0x1.
// R4 - Shift support field, bits 7:4, reads 0x4.
// R5 - Unprivileged access field, bits 3:0, reads 0x2.
// R6 - Software reads attribute four with opcode 0, c0, c2, opcode 4.
// R7 - Attribute register five reads zero; writes have no effect.
// R8 - Cache size register is read-only and not banked by security.
// R9 - Cache size register only reachable at privilege level one or above.
// R10 - Selection value picks which cache size value a read returns.
// R11 - Bit 31 set when selected cache supports write-through.
// R12 - Bit 30 set when selected cache supports write-back.
// R13 - Bit 29 set when selected cache allocates on read misses.
// R14 - Bit 28 set when selected cache allocates on write misses.
// R15 - Bits 27:13 hold set count minus one.
// R16 - Bits 12:3 hold number of ways minus one.
// R17 - Bits 2:0 hold log2 of words per line minus two.
// R18 - Selection 0 level-one data, 1 instruction, 2 level two; rest reserved.
module cid_bank
  import cid_pkg::*;
#(
  parameter logic [14:0] L1D_SETS = CID_L1D_SETS,
  parameter logic [14:0] L1I_SETS = CID_L1I_SETS,
  parameter logic [14:0] L2_SETS = CID_L2_SETS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Coprocessor access
  input wire cid_req_t cp_req,
  output logic cp_ready,
  output cid_rsp_t cp_rsp,
  // Current cache size selection
  input wire logic [3:0] cache_size_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  // Attribute space; the second opcode picks the register
  function automatic logic cid_in_isa_space(input cid_req_t r);
    logic hit;
    hit = 1'b0;
    if (r.opc1 == CID_OPC1_ISA) begin
      if (r.crn == CID_CRN_ISA) begin
        if (r.crm == CID_CRM_ISA) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction

  // Cache size register: one full encoding, nothing aliases it
  function automatic logic cid_is_ccs(input cid_req_t r);
    logic hit;
    hit = 1'b0;
    if (r.opc1 == CID_OPC1_CCS) begin
      if (r.crn == CID_CRN_CCS) begin
        if (r.crm == CID_CRM_CCS) begin
          if (r.opc2 == CID_OPC2_CCS) begin
            hit = 1'b1;
          end
        end
      end
    end
    return hit;
  endfunction

  // Shared by the read data and the fault paths
  function automatic cid_reg_t cid_decode(input cid_req_t r);
    cid_reg_t id;
    id = CID_REG_NONE;
    if (cid_in_isa_space(r)) begin
      case (r.opc2)
        CID_OPC2_ISA4: begin
          id = CID_REG_ISA4; // see R6
        end
        CID_OPC2_ISA5: begin
          id = CID_REG_ISA5;
        end
        default: begin
          id = CID_REG_NONE;
        end
      endcase
    end else if (cid_is_ccs(r)) begin
      id = CID_REG_CCS;
    end
    return id;
  endfunction

  // Packs one cache description into register layout
  function automatic logic [31:0] cid_pack(input cid_ccs_t c);
    logic [31:0] v;
    v = CID_ZERO;
    v[31] = c.write_through_flag; // see R11
    v[30] = c.write_back_flag; // see R12
    v[29] = c.read_allocate_flag; // see R13
    v[28] = c.write_allocate_flag; // see R14
    v[27:13] = c.set_count_minus_one; // see R15
    v[12:3] = c.ways_minus_one; // see R16
    v[2:0] = c.line_length_code; // see R17
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Constant register contents

  // Upper nibbles describe features served elsewhere in the core
  function automatic logic [31:0] cid_isa4_word();
    logic [31:0] v;
    v = CID_ZERO;
    v[31:28] = CID_ISA4_SWAP;
    v[27:24] = CID_ISA4_PSRM;
    v[23:20] = CID_ISA4_SYNCF;
    v[19:16] = CID_ISA4_BARRIER; // see R1
    v[15:12] = CID_ISA4_SECURE_CALL; // see R2
    v[11:8] = CID_ISA4_WRITEBACK; // see R3
    v[7:4] = CID_ISA4_SHIFT; // see R4
    v[3:0] = CID_ISA4_UNPRIV; // see R5
    return v;
  endfunction

  logic [31:0] isa4_value;
  assign isa4_value = cid_isa4_word();

  ////////////////////////////////////////////////////////////////////////////
  // Cache descriptions

  // Index order follows the selection encoding
  localparam int unsigned N_CACHE = 3;

  // One description per cache level and type
  function automatic cid_ccs_t cid_desc(input int unsigned idx);
    cid_ccs_t c;
    c = '0;
    case (idx)
      0: begin
        c.write_through_flag = 1'b0;
        c.write_back_flag = 1'b1;
        c.read_allocate_flag = 1'b1;
        c.write_allocate_flag = 1'b1;
        c.set_count_minus_one = L1D_SETS;
        c.ways_minus_one = CID_L1D_WAYS;
        c.line_length_code = CID_LINE_16W;
      end
      1: begin
        c.write_through_flag = 1'b0;
        c.write_back_flag = 1'b0;
        c.read_allocate_flag = 1'b1;
        c.write_allocate_flag = 1'b0;
        c.set_count_minus_one = L1I_SETS;
        c.ways_minus_one = CID_L1I_WAYS;
        c.line_length_code = CID_LINE_8W;
      end
      2: begin
        c.write_through_flag = 1'b0;
        c.write_back_flag = 1'b1;
        c.read_allocate_flag = 1'b1;
        c.write_allocate_flag = 1'b1;
        c.set_count_minus_one = L2_SETS;
        c.ways_minus_one = CID_L2_WAYS;
        c.line_length_code = CID_LINE_16W;
      end
      default: begin
        c = '0;
      end
    endcase
    return c;
  endfunction

  cid_ccs_t desc [N_CACHE];
  logic [31:0] ccs_word [N_CACHE];

  // Built once per cache so the selection mux only picks a word
  for (genvar g = 0; g < N_CACHE; g++) begin : g_cache
    assign desc[g] = cid_desc(g);
    assign ccs_word[g] = cid_pack(desc[g]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache size selection

  // Selection code for each table index
  function automatic logic [3:0] cid_sel_code(input int unsigned idx);
    logic [3:0] code;
    code = CID_SEL_L1D;
    case (idx)
      0: begin
        code = CID_SEL_L1D; // see R18
      end
      1: begin
        code = CID_SEL_L1I; // see R18
      end
      2: begin
        code = CID_SEL_L2; // see R18
      end
      default: begin
        code = CID_SEL_L1D;
      end
    endcase
    return code;
  endfunction

  // Reserved selections read zero rather than alias a real cache
  logic [31:0] ccs_value;

  always_comb begin
    ccs_value = CID_ZERO; // see R18
    for (int unsigned i = 0; i < N_CACHE; i++) begin
      if (cache_size_select == cid_sel_code(i)) begin
        ccs_value = ccs_word[i]; // see R10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access checking

  // Only the reserved attribute register swallows a write
  function automatic logic cid_write_ok(input cid_reg_t id);
    logic ok;
    ok = 1'b0;
    case (id)
      CID_REG_ISA5: begin
        ok = 1'b1; // see R7
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // Every mapped register answers a read
  function automatic logic cid_read_ok(input cid_reg_t id);
    logic ok;
    ok = 1'b0;
    case (id)
      CID_REG_ISA4: begin
        ok = 1'b1;
      end
      CID_REG_ISA5: begin
        ok = 1'b1;
      end
      CID_REG_CCS: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  cid_reg_t req_id;
  logic req_fault;
  logic [31:0] req_data;

  // No security-state input: one copy serves both worlds
  always_comb begin
    req_id = cid_decode(cp_req);
    req_fault = 1'b0;
    req_data = CID_ZERO;
    if (!cp_req.pl1) begin
      req_fault = 1'b1; // see R9
    end else if (cp_req.write) begin
      req_fault = !cid_write_ok(req_id); // see R8
    end else if (!cid_read_ok(req_id)) begin
      req_fault = 1'b1;
    end else begin
      case (req_id)
        CID_REG_ISA4: begin
          req_data = isa4_value;
        end
        CID_REG_CCS: begin
          req_data = ccs_value; // see R8
        end
        default: begin
          req_data = CID_ZERO; // see R7
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer sequencing

  // Every answer leaves through here so valid and data stay together
  function automatic cid_rsp_t cid_answer(input logic flt,
      input logic [31:0] data);
    cid_rsp_t a;
    a = '0;
    a.valid = 1'b1;
    a.fault = flt;
    a.rdata = flt ? CID_ZERO : data;
    return a;
  endfunction

  cid_regs_t regs_q;
  cid_regs_t regs_d;
  logic take;

  // One request every other cycle; enough for coprocessor traffic
  assign cp_ready = (regs_q.state == CID_IDLE);
  assign take = clk_en && cp_ready && cp_req.valid;

  always_comb begin
    regs_d = regs_q;
    regs_d.rsp.valid = 1'b0;
    case (regs_q.state)
      CID_IDLE: begin
        if (take) begin
          regs_d.state = CID_ANSWER;
          regs_d.rsp = cid_answer(req_fault, req_data);
        end
      end
      CID_ANSWER: begin
        regs_d.state = CID_IDLE;
      end
      default: begin
        regs_d.state = CID_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      regs_q.state <= CID_IDLE;
      regs_q.rsp <= '0;
    end else if (clk_en) begin
      regs_q <= regs_d;
    end
  end

  assign cp_rsp = regs_q.rsp;

endmodule

//--- tb/cid_bank_chk.sv
// Checker for the identification register bank.
// Assumes it is bound to the ports of the bank's top module.
module cid_bank_chk
  import cid_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Access port
  input wire cid_req_t cp_req,
  input wire logic cp_ready,
  input wire cid_rsp_t cp_rsp,
  input wire logic [3:0] cache_size_select
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers; encoding packed as opc1, crn, crm, opc2
  wire [13:0] enc = {cp_req.opc1, cp_req.crn, cp_req.crm, cp_req.opc2};
  wire take = clk_en & cp_req.valid & cp_ready;
  wire rd1 = take & ~cp_req.write & cp_req.pl1;
  sequence s_isa4;
    rd1 && enc == 14'h0014;
  endsequence
  sequence s_ok;
    cp_rsp.valid && !cp_rsp.fault;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_barrier;
    s_isa4 |=> s_ok ##0 cp_rsp.rdata[19:16] == 4'h1;
  endproperty
  property p_scall;
    s_isa4 |=> s_ok ##0 cp_rsp.rdata[15:12] == 4'h1;
  endproperty
  property p_wback;
    s_isa4 |=> s_ok ##0 cp_rsp.rdata[11:8] == 4'h1;
  endproperty
  property p_shift;
    s_isa4 |=> s_ok ##0 cp_rsp.rdata[7:4] == 4'h4;
  endproperty
  property p_unpriv;
    s_isa4 |=> s_ok ##0 cp_rsp.rdata[3:0] == 4'h2;
  endproperty
  property p_isa5;
    take && cp_req.pl1 && enc == 14'h0015 |=> s_ok ##0 cp_rsp.rdata == 32'h0;
  endproperty
  property p_ro;
    take && cp_req.write && enc == 14'h0800 |=> cp_rsp.valid && cp_rsp.fault;
  endproperty
  property p_priv;
    take && !cp_req.pl1 |=> cp_rsp.fault && cp_rsp.rdata == 32'h0;
  endproperty
  property p_l2;
    rd1 && enc == 14'h0800 && cache_size_select == 4'h2
      |=> s_ok ##0 cp_rsp.rdata == 32'h707F_E03A;
  endproperty
  property p_l1d;
    rd1 && enc == 14'h0800 && cache_size_select == 4'h0
      |=> s_ok ##0 cp_rsp.rdata == 32'h700F_E01A;
  endproperty
  // Busy cycle keeps takes two edges apart
  property p_busy;
    take |=> !cp_ready;
  endproperty
  a_barrier: assert property (p_barrier) else $error("barrier field");
  a_scall: assert property (p_scall) else $error("secure field");
  a_wback: assert property (p_wback) else $error("writeback field");
  a_shift: assert property (p_shift) else $error("shift field");
  a_unpriv: assert property (p_unpriv) else $error("unpriv field");
  a_isa5: assert property (p_isa5) else $error("attr5 not zero");
  a_ro: assert property (p_ro) else $error("write not refused");
  a_priv: assert property (p_priv) else $error("low privilege");
  a_l2: assert property (p_l2) else $error("level two value");
  a_l1d: assert property (p_l1d) else $error("level one data");
  a_busy: assert property (p_busy) else $error("ready after take");
endmodule

//--- tb/tb_cid_bank.sv
// Self-checking bench for the identification register bank.
// Assumes the package and checker are compiled first.
module tb_cid_bank
  import cid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic w;
    logic pl;
    logic [13:0] enc;
    logic [3:0] sel;
    logic flt;
    logic [31:0] rd;
  } cid_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  cid_req_t cp_req = '0;
  logic [3:0] cache_size_select = 4'h0;
  logic cp_ready;
  cid_rsp_t cp_rsp;
  int n_fail = 0;
  int total_checks = 0;
  cid_row_t rows [13] = '{
    '{1'b0, 1'b1, 14'h0014, 4'h0, 1'b0, 32'h1001_1142},
    '{1'b0, 1'b1, 14'h0015, 4'h0, 1'b0, 32'h0},
    '{1'b1, 1'b1, 14'h0015, 4'h0, 1'b0, 32'h0},
    '{1'b0, 1'b1, 14'h0800, 4'h0, 1'b0, 32'h700F_E01A},
    '{1'b0, 1'b1, 14'h0800, 4'h1, 1'b0, 32'h203F_E009},
    '{1'b0, 1'b1, 14'h0800, 4'h2, 1'b0, 32'h707F_E03A},
    '{1'b0, 1'b1, 14'h0800, 4'h3, 1'b0, 32'h0},
    '{1'b0, 1'b1, 14'h0800, 4'hF, 1'b0, 32'h0},
    '{1'b1, 1'b1, 14'h0014, 4'h0, 1'b1, 32'h0},
    '{1'b1, 1'b1, 14'h0800, 4'h0, 1'b1, 32'h0},
    '{1'b0, 1'b0, 14'h0014, 4'h0, 1'b1, 32'h0},
    '{1'b0, 1'b0, 14'h0800, 4'h2, 1'b1, 32'h0},
    '{1'b0, 1'b1, 14'h0016, 4'h0, 1'b1, 32'h0}
  };
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  cid_bank dut (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cp_req(cp_req),
    .cp_ready(cp_ready),
    .cp_rsp(cp_rsp),
    .cache_size_select(cache_size_select)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Selection flipped after the take: a late sample would show
  task automatic do_req(input cid_row_t r);
    int n;
    n = 0;
    @(posedge core_clk);
    cp_req <= '{1'b1, r.w, r.pl, r.enc[13:11], r.enc[10:7], r.enc[6:3],
                r.enc[2:0], 32'hFFFF_FFFF};
    cache_size_select <= r.sel;
    @(negedge core_clk);
    while (cp_ready !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_fail++;
        final_report();
      end
      @(negedge core_clk);
    end
    @(posedge core_clk);
    cp_req.valid <= 1'b0;
    cache_size_select <= ~r.sel;
    @(negedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    repeat (7) @(negedge core_clk);
    chk({1'b0, cp_ready, cp_rsp}, {2'b01, 34'h0});
    @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      do_req(rows[i]);
      chk({2'b00, cp_rsp}, {3'b001, rows[i].flt, rows[i].rd});
    end
    // Answer is a pulse; data holds
    do_req(rows[0]);
    @(negedge core_clk);
    chk({2'b00, cp_rsp}, {4'h0, 32'h1001_1142});
    // Frozen clock enable takes nothing
    @(posedge core_clk);
    clk_en <= 1'b0;
    cp_req <= '{1'b1, 1'b0, 1'b1, 3'h0, 4'h0, 4'h2, 3'h5, 32'h0};
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    @(negedge core_clk);
    chk({2'b00, cp_rsp}, {4'h0, 32'h1001_1142});
    @(posedge core_clk);
    cp_req.valid <= 1'b0;
    @(negedge core_clk);
    chk({2'b00, cp_rsp}, {4'h2, 32'h0});
    // Second reset mid-run, with live data to clear
    do_req(rows[3]);
    chk({2'b00, cp_rsp}, {4'h2, 32'h700F_E01A});
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk({1'b0, cp_ready, cp_rsp}, {2'b01, 34'h0});
    @(posedge core_clk);
    rst <= 1'b0;
    do_req(rows[4]);
    chk({2'b00, cp_rsp}, {4'h2, 32'h203F_E009});
    final_report();
  end
endmodule

bind cid_bank cid_bank_chk u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .clk_en(clk_en),
  .cp_req(cp_req),
  .cp_ready(cp_ready),
  .cp_rsp(cp_rsp),
  .cache_size_select(cache_size_select)
);
